// File: hdl/psr_status_regs.sv
// status and identifier registers behind the serial management interface
// assumes mdc and mdioIn arrive from pins; link, jabber and speed come from ref_clk logic
`timescale 1ns/100ps
`include "psr_defines.svh"

module psr_status_regs (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOeN,
  input wire logic linkGood,
  input wire logic jabberSeen,
  input wire logic speed100,
  output logic linkStatus,
  output logic jabberStatus
);

  // ****************************************
  // register read value
  // ****************************************
  function automatic logic slowJabber(input logic seen, input logic fast);
    return seen & ~fast;
  endfunction

  function automatic logic [15:0] statusWord(input psr_pkg::psr_status_t st);
    logic [15:0] w;
    w = 16'h0000;
    w[`PSR_BIT_LINK] = st.linkValid;
    w[`PSR_BIT_JABBER] = st.jabber;
    w[`PSR_BIT_EXTCAP] = 1'b1;
    return w;
  endfunction

  function automatic logic [15:0] regValue(input logic [4:0] addr, input psr_pkg::psr_status_t st);
    logic [15:0] v;
    v = 16'h0000;
    case (addr)
      `PSR_REG_STATUS: begin
        v = statusWord(st);
      end
      `PSR_REG_ID_HIGH: begin
        v = `PSR_ORG_CODE_UPPER;
      end
      `PSR_REG_ID_LOW: begin
        v = {`PSR_ORG_CODE_LOWER, `PSR_VENDOR_MODEL, `PSR_MODEL_REVISION};
      end
      default: begin
        v = 16'h0000;
      end
    endcase
    return v;
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic mdcSync1_q, mdcSync2_q, mdcPrev_q;
  logic mdcSync1_d, mdcSync2_d, mdcPrev_d;

  always_comb begin
    mdcSync1_d = mdc;
    mdcSync2_d = mdcSync1_q;
    mdcPrev_d = mdcSync2_q;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mdcSync1_q <= 1'b0;
      mdcSync2_q <= 1'b0;
      mdcPrev_q <= 1'b0;
    end else begin
      mdcSync1_q <= mdcSync1_d;
      mdcSync2_q <= mdcSync2_d;
      mdcPrev_q <= mdcPrev_d;
    end
  end

  logic mdioSync1_q, mdioSync2_q;
  logic mdioSync1_d, mdioSync2_d;

  always_comb begin
    mdioSync1_d = mdioIn;
    mdioSync2_d = mdioSync1_q;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mdioSync1_q <= 1'b1;
      mdioSync2_q <= 1'b1;
    end else begin
      mdioSync1_q <= mdioSync1_d;
      mdioSync2_q <= mdioSync2_d;
    end
  end

  logic mdcRise;
  logic bitIn;
  assign mdcRise = mdcSync2_q & ~mdcPrev_q;
  assign bitIn = mdioSync2_q;

  // ****************************************
  // management frame engine
  // ****************************************
  psr_pkg::psr_state_t state_q, state_d;
  logic [4:0] cnt_q, cnt_d;
  logic [11:0] shiftIn_q, shiftIn_d;
  logic [15:0] txShift_q, txShift_d;
  logic mdioOut_q, mdioOut_d, mdioOeN_q, mdioOeN_d;
  logic statusRead;
  psr_pkg::psr_status_t status_q, status_d;

  always_comb begin
    logic [11:0] cmd;
    cmd = {shiftIn_q[10:0], bitIn};
    statusRead = 1'b0;
    state_d = state_q;
    cnt_d = cnt_q;
    shiftIn_d = shiftIn_q;
    txShift_d = txShift_q;
    mdioOut_d = mdioOut_q;
    mdioOeN_d = mdioOeN_q;
    if (mdcRise) begin
      case (state_q)
        psr_pkg::PSR_IDLE: begin
          if (!bitIn) begin
            state_d = psr_pkg::PSR_START;
          end
        end
        psr_pkg::PSR_START: begin
          state_d = bitIn ? psr_pkg::PSR_CMD : psr_pkg::PSR_IDLE;
          cnt_d = 5'h00;
        end
        psr_pkg::PSR_CMD: begin
          shiftIn_d = cmd;
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == `PSR_CMD_LAST) begin
            cnt_d = 5'h00;
            if (cmd[11:10] == `PSR_OP_READ && cmd[9:5] == `PSR_PHY_ADDR) begin
              state_d = psr_pkg::PSR_TURN;
              txShift_d = regValue(cmd[4:0], status_q);
              statusRead = (cmd[4:0] == `PSR_REG_STATUS);
            end else begin
              state_d = psr_pkg::PSR_SKIP;
            end
          end
        end
        psr_pkg::PSR_TURN: begin
          mdioOut_d = 1'b0;
          mdioOeN_d = 1'b0;
          state_d = psr_pkg::PSR_DATA;
        end
        psr_pkg::PSR_DATA: begin
          cnt_d = cnt_q + 5'h01;
          mdioOut_d = txShift_q[15];
          txShift_d = {txShift_q[14:0], 1'b0};
          if (cnt_q == `PSR_DATA_BITS) begin
            mdioOut_d = 1'b1;
            mdioOeN_d = 1'b1;
            state_d = psr_pkg::PSR_IDLE;
          end
        end
        psr_pkg::PSR_SKIP: begin
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == `PSR_SKIP_LAST) begin
            state_d = psr_pkg::PSR_IDLE;
          end
        end
        default: begin
          state_d = psr_pkg::PSR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= psr_pkg::PSR_IDLE;
      cnt_q <= 5'h00;
      shiftIn_q <= 12'h000;
      txShift_q <= 16'h0000;
      mdioOut_q <= 1'b1;
      mdioOeN_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shiftIn_q <= shiftIn_d;
      txShift_q <= txShift_d;
      mdioOut_q <= mdioOut_d;
      mdioOeN_q <= mdioOeN_d;
    end
  end

  // ****************************************
  // status latches
  // ****************************************
  always_comb begin
    status_d.linkValid = status_q.linkValid & linkGood;
    status_d.jabber = status_q.jabber | slowJabber(jabberSeen, speed100);
    if (statusRead) begin
      status_d.linkValid = linkGood;
      status_d.jabber = slowJabber(jabberSeen, speed100);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_q.linkValid <= `PSR_LINK_RESET;
      status_q.jabber <= `PSR_JABBER_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign mdioOut = mdioOut_q;
  assign mdioOeN = mdioOeN_q;
  assign linkStatus = status_q.linkValid;
  assign jabberStatus = status_q.jabber;

endmodule

// File: hdl/psr_defines.svh
// constants for the phy status and identifier register block
// assumes the management frame engine in psr_status_regs includes it
//
// How it works
// - status bit 2 reads one while a valid 10 or 100 Mbps link holds and zero when no link exists.
// - any link failure clears the link-valid bit at once, read or no read.
// - once cleared, the link-valid bit returns to one only when the link is good and the register is read.
// - the jabber bit only means something at 10 Mbps, so jabber at 100 Mbps does not set it.
// - a jabber event sets status bit 1, which stays set until a read of status register 0x01 or a reset clears it.
// - status bit 0 always reads one to show that extended registers exist.
// - the two identifier registers return the organization code, model number and revision as 32 bits.
// - register 0x02 carries organization-code bits 3 to 18 in its bits 15 to 0.
// - the two lowest organization-code bits, 1 and 2, do not appear in either identifier register.
// - register 0x03 carries organization-code bits 19 to 24 in its bits 15 to 10.
// - the six-bit model number sits in bits 9 to 4 of register 0x03, msb at bit 9.
// - the four-bit revision sits in bits 3 to 0 of register 0x03, msb at bit 3.
`ifndef PSR_DEFINES_SVH
`define PSR_DEFINES_SVH

// ****************************************
// register offsets
// ****************************************
`define PSR_REG_STATUS 5'h01
`define PSR_REG_ID_HIGH 5'h02
`define PSR_REG_ID_LOW 5'h03

// ****************************************
// status field positions and reset values
// ****************************************
`define PSR_BIT_LINK 4'h2
`define PSR_BIT_JABBER 4'h1
`define PSR_BIT_EXTCAP 4'h0
`define PSR_LINK_RESET 1'h0
`define PSR_JABBER_RESET 1'h0

// ****************************************
// identifier fields, values arbitrary
// ****************************************
`define PSR_ORG_CODE_UPPER 16'h5A3C
`define PSR_ORG_CODE_LOWER 6'h15
`define PSR_VENDOR_MODEL 6'h2A
`define PSR_MODEL_REVISION 4'h3

// ****************************************
// management frame
// ****************************************
`define PSR_PHY_ADDR 5'h01
`define PSR_OP_READ 2'h2
`define PSR_CMD_LAST 5'h0B
`define PSR_DATA_BITS 5'h10
`define PSR_SKIP_LAST 5'h11

`endif

// File: hdl/psr_pkg.sv
// types for the phy status and identifier register block
// assumes psr_defines.svh carries the register, field and frame constants
package psr_pkg;

  typedef enum logic [2:0] {
    PSR_IDLE = 3'b000,
    PSR_START = 3'b001,
    PSR_CMD = 3'b010,
    PSR_TURN = 3'b011,
    PSR_DATA = 3'b100,
    PSR_SKIP = 3'b101
  } psr_state_t;

  typedef struct packed {
    logic linkValid;
    logic jabber;
  } psr_status_t;

endpackage

// File: test/psr_status_properties.sv
// port checker for the status and identifier block
// assumes a bind onto psr_status_regs and an mdc of ten ref_clk periods
`timescale 1ns/100ps
module psr_status_properties (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic mdioOut,
  input wire logic mdioOeN,
  input wire logic linkGood,
  input wire logic jabberSeen,
  input wire logic speed100,
  input wire logic linkStatus,
  input wire logic jabberStatus
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  // ****
  // assertions
  // ****
  link_drop_a: assert property (!linkGood |=> !linkStatus)
    else $error("link bit kept after failure");
  link_hold_a: assert property (linkStatus && linkGood |=> linkStatus)
    else $error("link bit lost on good link");
  link_rise_a: assert property ($rose(linkStatus) |-> $past(linkGood) ##[1:20] !mdioOeN)
    else $error("link bit set without read");
  jab_set_a: assert property (jabberSeen && !speed100 |=> jabberStatus)
    else $error("jabber bit not set");
  jab_fast_a: assert property ($rose(jabberStatus) |-> $past(jabberSeen) && !$past(speed100))
    else $error("jabber bit set without slow jabber");
  jab_clear_a: assert property ($fell(jabberStatus) |-> ##[1:20] !mdioOeN)
    else $error("jabber bit cleared without read");
  turn_zero_a: assert property ($fell(mdioOeN) |-> !mdioOut)
    else $error("turnaround bit not zero");
  drive_span_a: assert property ($fell(mdioOeN) |=> !mdioOeN [*8])
    else $error("data phase cut short");
  cover property ($fell(mdioOeN));
  cover property ($fell(jabberStatus));
  cover property ($rose(linkStatus));
endmodule
bind psr_status_regs psr_status_properties psr_status_properties_inst (.ref_clk(ref_clk), .reset_n(reset_n),
  .mdioOut(mdioOut), .mdioOeN(mdioOeN), .linkGood(linkGood), .jabberSeen(jabberSeen), .speed100(speed100),
  .linkStatus(linkStatus), .jabberStatus(jabberStatus));

// File: test/psr_mgmt_host.sv
// station management controller model
// assumes the bench resolves the shared data line with a pull-up
`timescale 1ns/100ps
`include "psr_defines.svh"
module psr_mgmt_host (
  input wire logic ref_clk,
  output logic mdc,
  output logic drvEn,
  output logic drvBit,
  input wire logic mdioLine
);
  initial begin
    mdc = 1'b0;
    drvEn = 1'b0;
    drvBit = 1'b1;
  end
  // one frame; mdc stands low between frames, data sampled before each rise
  task automatic xfer(input logic [1:0] op, input logic [4:0] regAddr, input logic [15:0] wd,
                      output logic [15:0] rd);
    logic [31:0] frame;
    frame = {2'h1, op, `PSR_PHY_ADDR, regAddr, 2'h2, wd};
    rd = 16'h0000;
    for (int i = 0; i < 34; i++) begin
      @(negedge ref_clk);
      mdc = 1'b0;
      drvEn = (i < 32) && (op != `PSR_OP_READ || i < 14);
      drvBit = (i < 32) ? frame[31 - i] : 1'b1;
      repeat (4) @(negedge ref_clk);
      if (i >= 16 && i < 32) rd[31 - i] = mdioLine;
      mdc = 1'b1;
      repeat (5) @(negedge ref_clk);
    end
    mdc = 1'b0;
    drvEn = 1'b0;
  endtask
endmodule

// File: test/tb_psr_status_regs.sv
// self-checking bench for the status and identifier block
// assumes the host model drives mdc and its share of the data line
`timescale 1ns/100ps
`include "psr_defines.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_psr_status_regs;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic linkGood = 1'b0;
  logic jabberSeen = 1'b0;
  logic speed100 = 1'b0;
  logic mdc, drvEn, drvBit, mdioOut, mdioOeN, linkStatus, jabberStatus, mdioLine;
  logic [15:0] rd;
  int fails = 0;
  int checks = 0;
  assign mdioLine = !mdioOeN ? mdioOut : (drvEn ? drvBit : 1'b1);
  always #20 ref_clk = ~ref_clk;
  psr_status_regs psr_status_regs_inst (.ref_clk(ref_clk), .reset_n(reset_n), .mdc(mdc), .mdioIn(mdioLine),
    .mdioOut(mdioOut), .mdioOeN(mdioOeN), .linkGood(linkGood), .jabberSeen(jabberSeen), .speed100(speed100),
    .linkStatus(linkStatus), .jabberStatus(jabberStatus));
  psr_mgmt_host psr_mgmt_host_inst (.ref_clk(ref_clk), .mdc(mdc), .drvEn(drvEn), .drvBit(drvBit),
    .mdioLine(mdioLine));
  task automatic rdChk(input logic [4:0] a, input logic [15:0] e);
    psr_mgmt_host_inst.xfer(`PSR_OP_READ, a, 16'h0000, rd);
    `CHK(rd, e)
  endtask
  task automatic pulse(input logic fast);
    speed100 = fast;
    jabberSeen = 1'b1;
    @(negedge ref_clk);
    jabberSeen = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic results;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // watchdog: about twenty frames of 340 cycles each, with ample margin
  initial begin
    #400000;
    fails++;
    results;
  end
  initial begin
    repeat (5) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    rdChk(5'h01, 16'h0001);
    linkGood = 1'b1;
    rdChk(5'h01, 16'h0001);
    rdChk(5'h01, 16'h0005);
    $display("link test done");
    linkGood = 1'b0;
    @(negedge ref_clk);
    linkGood = 1'b1;
    `CHK(linkStatus, 1'b0)
    rdChk(`PSR_REG_ID_LOW, 16'h56A3);
    rdChk(5'h01, 16'h0001);
    rdChk(5'h01, 16'h0005);
    $display("link drop test done");
    pulse(1'b1);
    rdChk(5'h01, 16'h0005);
    pulse(1'b0);
    `CHK(jabberStatus, 1'b1)
    rdChk(`PSR_REG_ID_HIGH, `PSR_ORG_CODE_UPPER);
    rdChk(5'h01, 16'h0007);
    rdChk(5'h01, 16'h0005);
    $display("jabber test done");
    rdChk(`PSR_REG_ID_HIGH, `PSR_ORG_CODE_UPPER);
    rdChk(`PSR_REG_ID_LOW, 16'h56A3);
    psr_mgmt_host_inst.xfer(2'h1, `PSR_REG_ID_HIGH, 16'h0000, rd);
    psr_mgmt_host_inst.xfer(2'h1, `PSR_REG_STATUS, 16'hfff8, rd);
    rdChk(`PSR_REG_ID_HIGH, `PSR_ORG_CODE_UPPER);
    rdChk(`PSR_REG_STATUS, 16'h0005);
    $display("identifier test done");
    pulse(1'b0);
    `CHK(jabberStatus, 1'b1)
    reset_n = 1'b0;
    @(negedge ref_clk);
    `CHK(jabberStatus, 1'b0)
    `CHK(linkStatus, 1'b0)
    reset_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    rdChk(`PSR_REG_STATUS, 16'h0001);
    rdChk(`PSR_REG_STATUS, 16'h0005);
    $display("reset test done");
    results;
  end
endmodule
